// ### cgr_pkg.sv
// Constants and types shared by the clock global control register bank
// What this block does
// R1 - Bit 5 of the global enable register at 0x0003 turns on RF reseeding of the SYSREF path.
// R2 - Bit 2 of the global enable register turns on the internal SYSREF timing reference.
// R3 - Bit 1 of the global enable register is the master enable of the synthesis loop.
// R4 - Bit 0 of the global enable register is the master enable of the reference loop.
// R5 - Bits 6 to 0 at 0x0004 each enable output channels 2k and 2k+1, with bit 7 reserved.
// R6 - The SYNC pin field at 0x0005 bits 7:6 ignores the pin at 00 and at 01 sends its rising edge through the synthesis loop.
// R7 - At SYNC pin mode 10 a pin event requests a pulse-generator stream from channels set for dynamic startup.
// R8 - A pin-requested pulse stream is the same request as one raised through the general input pin.
// R9 - At SYNC pin mode 11 a pin event causes a sync when an alarm is present and a pulse-generator request otherwise.
// R10 - Bit 5 at 0x0005 dedicates reference input one to an external oscillator.
// R11 - Bit 4 at 0x0005 dedicates reference input zero to an external RF sync.
// R12 - Bits 3 to 0 at 0x0005 enable the reference-loop input paths, input 0 at bit 0 through input 3 at bit 3.
// R13 - The register at 0x0008 is freely writable and readable and affects nothing in the device.
// R14 - The host may write the scratch register and read it back to prove its access path.
// R15 - With bit 0 at 0x0009 clear, the synthesis loop sends a sync up its feedback divider once lock is reached.
// R16 - With bit 0 at 0x0009 set, no internal sync is made on synthesis-loop lock.
// R17 - Writing 1 to bit 0 at 0x0006 clears all latched alarms until software writes it back to 0.
package cgr_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int INSTR_BITS = 16;
   localparam int FRAME_BITS = 24;
   localparam int RW_BIT = 15;

   localparam logic [12:0] OFS_GLOBAL_ENABLE = 13'h0003;
   localparam logic [12:0] OFS_OUTPUT_PAIR_ENABLE = 13'h0004;
   localparam logic [12:0] OFS_GLOBAL_MODE_ENABLE = 13'h0005;
   localparam logic [12:0] OFS_ALARM_CLEAR = 13'h0006;
   localparam logic [12:0] OFS_MISC_RESERVED = 13'h0007;
   localparam logic [12:0] OFS_SCRATCH = 13'h0008;
   localparam logic [12:0] OFS_LOCK_SYNC_CONTROL = 13'h0009;

   localparam logic [7:0] RST_GLOBAL_ENABLE = 8'h00;
   localparam logic [7:0] RST_OUTPUT_PAIR_ENABLE = 8'h00;
   localparam logic [7:0] RST_GLOBAL_MODE_ENABLE = 8'h00;
   localparam logic [7:0] RST_ALARM_CLEAR = 8'h00;
   localparam logic [7:0] RST_MISC_RESERVED = 8'h00;
   localparam logic [7:0] RST_SCRATCH = 8'h00;
   localparam logic [7:0] RST_LOCK_SYNC_CONTROL = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // global_enable fields
   localparam int BIT_REF_LOOP_EN = 0;
   localparam int BIT_SYNTH_LOOP_EN = 1;
   localparam int BIT_SYSREF_TIMER_EN = 2;
   localparam int POS_VCO_SELECT = 3;
   localparam int BIT_RF_RESEED_EN = 5;
   // output_pair_enable field
   localparam int PAIR_COUNT = 7;
   // global_mode_enable fields
   localparam int POS_REF_PATH_EN = 0;
   localparam int REF_INPUTS = 4;
   localparam int BIT_REF_ZERO_RF_SYNC = 4;
   localparam int BIT_REF_ONE_EXT_OSC = 5;
   localparam int POS_SYNC_MODE = 6;
   // alarm_clear and lock_sync_control fields
   localparam int BIT_CLEAR_ALARMS = 0;
   localparam int BIT_LOCK_SYNC_DISABLE = 0;

   typedef enum logic [1:0] {
      SYNC_MODE_OFF = 2'h0,
      SYNC_MODE_SYNC = 2'h1,
      SYNC_MODE_PULSE = 2'h2,
      SYNC_MODE_AUTO = 2'h3
   } cgr_sync_mode_t;
endpackage : cgr_pkg

// ### cgr_reg_if.sv
// Register access carrier between serial port engine and register bank
`timescale 1ns/1ns
interface cgr_reg_if;
   logic wr_en;
   logic rd_en;
   logic [cgr_pkg::ADDR_W-1:0] addr;
   logic [cgr_pkg::DATA_W-1:0] wdata;
   logic [cgr_pkg::DATA_W-1:0] rdata;

   modport port (output wr_en, output rd_en, output addr, output wdata, input rdata);
   modport bank (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : cgr_reg_if

// ### cgr_serial_port.sv
// Serial control port engine: 16-bit instruction then byte-wide data
`timescale 1ns/1ns
module cgr_serial_port (
   input wire logic clock, // System clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic sclk, // Serial clock, sampled
   input wire logic sen_n, // Serial enable, active low
   input wire logic sdio_in, // Serial data from host
   output logic sdio_out, // Serial data to host
   output logic sdio_oe, // High while driving sdio
   cgr_reg_if.port regs // Register access toward bank
);
   typedef struct packed {
      logic sclk_prev;
      logic [4:0] count;
      logic is_read;
      logic [cgr_pkg::ADDR_W-1:0] addr;
      logic [cgr_pkg::INSTR_BITS-2:0] shift_in;
      logic [cgr_pkg::DATA_W-1:0] shift_out;
   } cgr_sp_state_t;

   cgr_sp_state_t state;
   cgr_sp_state_t next_state;
   logic rise;
   logic fall;
   logic instr_done;
   logic byte_done;

   always_comb begin
      next_state = state;
      rise = sclk & ~state.sclk_prev;
      fall = ~sclk & state.sclk_prev;
      instr_done = rise & (state.count == 5'(cgr_pkg::INSTR_BITS - 1));
      byte_done = rise & (state.count == 5'(cgr_pkg::FRAME_BITS - 1));
      regs.wr_en = 1'b0;
      regs.rd_en = 1'b0;
      regs.addr = state.addr;
      regs.wdata = {state.shift_in[cgr_pkg::DATA_W-2:0], sdio_in};
      next_state.sclk_prev = sclk;
      if (sen_n) begin
         next_state.count = 5'h00;
         next_state.is_read = 1'b0;
      end else if (rise) begin
         next_state.shift_in = {state.shift_in[cgr_pkg::INSTR_BITS-3:0], sdio_in};
         next_state.count = byte_done ? 5'(cgr_pkg::INSTR_BITS) : state.count + 5'h01;
         if (instr_done) begin
            next_state.is_read = state.shift_in[cgr_pkg::RW_BIT-1];
            next_state.addr = {state.shift_in[cgr_pkg::ADDR_W-2:0], sdio_in};
            regs.addr = next_state.addr;
            regs.rd_en = state.shift_in[cgr_pkg::RW_BIT-1];
            next_state.shift_out = regs.rdata;
         end else if (byte_done) begin
            // Streaming walks downward through the map
            next_state.addr = state.addr - 13'h0001;
            regs.wr_en = ~state.is_read;
            regs.addr = state.addr;
            regs.rd_en = state.is_read;
            if (state.is_read) begin
               regs.addr = next_state.addr;
               next_state.shift_out = regs.rdata;
            end
         end
      end else if (fall && state.is_read && state.count != 5'(cgr_pkg::INSTR_BITS)) begin
         next_state.shift_out = {state.shift_out[cgr_pkg::DATA_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sdio_out = state.shift_out[cgr_pkg::DATA_W-1];
   assign sdio_oe = ~sen_n & state.is_read;
endmodule : cgr_serial_port

// ### cgr_sync_events.sv
// Sync pin, general input and lock-sync event steering
`timescale 1ns/1ns
module cgr_sync_events (
   input wire logic clock, // System clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic sync_pin, // SYNC pin level
   input wire logic general_input_pin_pulse, // Pulse request level from general input pin
   input wire logic synthesis_loop_locked, // Synthesis loop lock level
   input wire logic alarm_present, // Any alarm active
   input wire logic [1:0] sync_mode, // SYNC pin function
   input wire logic lock_sync_disable, // Suppress sync on lock
   output logic synthesis_loop_sync, // Sync edge sent through synthesis loop
   output logic pulse_gen_request, // Pulse stream request to dynamic channels
   output logic feedback_divider_sync // Sync sent up feedback divider on lock
);
   typedef struct packed {
      logic sync_prev;
      logic gpi_prev;
      logic lock_prev;
      logic sync_out;
      logic pulse_out;
      logic fbd_out;
   } cgr_ev_state_t;

   cgr_ev_state_t state;
   cgr_ev_state_t next_state;
   logic pin_event;
   logic gpi_event;

   always_comb begin
      next_state = state;
      pin_event = sync_pin & ~state.sync_prev;
      gpi_event = general_input_pin_pulse & ~state.gpi_prev;
      next_state.sync_prev = sync_pin;
      next_state.gpi_prev = general_input_pin_pulse;
      next_state.lock_prev = synthesis_loop_locked;
      next_state.sync_out = 1'b0;
      next_state.pulse_out = gpi_event; // [R8]
      unique case (cgr_pkg::cgr_sync_mode_t'(sync_mode))
         cgr_pkg::SYNC_MODE_OFF: begin
         end // [R6]
         cgr_pkg::SYNC_MODE_SYNC: next_state.sync_out = pin_event; // [R6]
         cgr_pkg::SYNC_MODE_PULSE: begin
            next_state.pulse_out = gpi_event | pin_event; // [R7] [R8]
         end
         cgr_pkg::SYNC_MODE_AUTO: begin
            next_state.sync_out = pin_event & alarm_present; // [R9]
            next_state.pulse_out = gpi_event | (pin_event & ~alarm_present); // [R9] [R8]
         end
      endcase
      // Only the lock rising edge fires, so a held lock makes one event
      next_state.fbd_out = synthesis_loop_locked & ~state.lock_prev & ~lock_sync_disable; // [R15] [R16]
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign synthesis_loop_sync = state.sync_out;
   assign pulse_gen_request = state.pulse_out;
   assign feedback_divider_sync = state.fbd_out;
endmodule : cgr_sync_events

// ### cgr_global_regs.sv
// Global control register bank with serial port and sync event steering
`timescale 1ns/1ns
module cgr_global_regs (
   input wire logic clock, // System clock, 50 MHz
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic sclk, // Serial port clock
   input wire logic sen_n, // Serial port enable, active low
   input wire logic sdio_in, // Serial data in
   output logic sdio_out, // Serial data out
   output logic sdio_oe, // Serial data output enable
   input wire logic sync_pin, // SYNC pin
   input wire logic general_input_pin_pulse, // Pulse request from general input pin
   input wire logic synthesis_loop_locked, // Synthesis loop lock status
   input wire logic alarm_present, // Alarm status from alarm logic
   output logic reference_loop_enable, // Reference loop master enable
   output logic synthesis_loop_enable, // Synthesis loop master enable
   output logic sysref_timer_enable, // Internal SYSREF timer enable
   output logic rf_reseed_enable, // RF reseeder enable for SYSREF
   output logic [1:0] vco_select, // Oscillator selection field
   output logic [13:0] channel_enable, // Per-channel output enables
   output logic [3:0] ref_path_enable, // Reference-loop input path enables
   output logic ref_input_zero_rf_sync, // Input zero used as RF sync
   output logic ref_input_one_ext_osc, // Input one used as external oscillator
   output logic alarm_clear, // Clear latched alarms, level
   output logic synthesis_loop_sync, // Sync pulse through synthesis loop
   output logic pulse_gen_request, // Pulse generator request pulse
   output logic feedback_divider_sync // Lock sync pulse up feedback divider
);
   typedef struct packed {
      logic [7:0] global_enable;
      logic [7:0] output_pair_enable;
      logic [7:0] global_mode_enable;
      logic [7:0] alarm_clear;
      logic [7:0] misc_reserved;
      logic [7:0] scratch;
      logic [7:0] lock_sync_control;
   } cgr_regs_t;

   cgr_regs_t state;
   cgr_regs_t next_state;
   cgr_reg_if reg_bus ();

   cgr_serial_port u_port (
      .clock(clock),
      .resetn(resetn),
      .sclk(sclk),
      .sen_n(sen_n),
      .sdio_in(sdio_in),
      .sdio_out(sdio_out),
      .sdio_oe(sdio_oe),
      .regs(reg_bus.port)
   );

   // Every printed bit is read-write, so reserved bits keep what was written
   always_comb begin
      next_state = state;
      if (reg_bus.wr_en) begin
         unique case (reg_bus.addr)
            cgr_pkg::OFS_GLOBAL_ENABLE: next_state.global_enable = reg_bus.wdata;
            cgr_pkg::OFS_OUTPUT_PAIR_ENABLE: next_state.output_pair_enable = reg_bus.wdata;
            cgr_pkg::OFS_GLOBAL_MODE_ENABLE: next_state.global_mode_enable = reg_bus.wdata;
            cgr_pkg::OFS_ALARM_CLEAR: next_state.alarm_clear = reg_bus.wdata;
            cgr_pkg::OFS_MISC_RESERVED: next_state.misc_reserved = reg_bus.wdata;
            cgr_pkg::OFS_SCRATCH: next_state.scratch = reg_bus.wdata; // [R13] [R14]
            cgr_pkg::OFS_LOCK_SYNC_CONTROL: next_state.lock_sync_control = reg_bus.wdata;
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      unique case (reg_bus.addr)
         cgr_pkg::OFS_GLOBAL_ENABLE: reg_bus.rdata = state.global_enable;
         cgr_pkg::OFS_OUTPUT_PAIR_ENABLE: reg_bus.rdata = state.output_pair_enable;
         cgr_pkg::OFS_GLOBAL_MODE_ENABLE: reg_bus.rdata = state.global_mode_enable;
         cgr_pkg::OFS_ALARM_CLEAR: reg_bus.rdata = state.alarm_clear;
         cgr_pkg::OFS_MISC_RESERVED: reg_bus.rdata = state.misc_reserved;
         cgr_pkg::OFS_SCRATCH: reg_bus.rdata = state.scratch; // [R13] [R14]
         cgr_pkg::OFS_LOCK_SYNC_CONTROL: reg_bus.rdata = state.lock_sync_control;
         default: reg_bus.rdata = cgr_pkg::UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state <= {cgr_pkg::RST_GLOBAL_ENABLE, cgr_pkg::RST_OUTPUT_PAIR_ENABLE,
                   cgr_pkg::RST_GLOBAL_MODE_ENABLE, cgr_pkg::RST_ALARM_CLEAR,
                   cgr_pkg::RST_MISC_RESERVED, cgr_pkg::RST_SCRATCH,
                   cgr_pkg::RST_LOCK_SYNC_CONTROL};
      end else begin
         state <= next_state;
      end
   end

   assign reference_loop_enable = state.global_enable[cgr_pkg::BIT_REF_LOOP_EN]; // [R4]
   assign synthesis_loop_enable = state.global_enable[cgr_pkg::BIT_SYNTH_LOOP_EN]; // [R3]
   assign sysref_timer_enable = state.global_enable[cgr_pkg::BIT_SYSREF_TIMER_EN]; // [R2]
   assign rf_reseed_enable = state.global_enable[cgr_pkg::BIT_RF_RESEED_EN]; // [R1]
   assign vco_select = state.global_enable[cgr_pkg::POS_VCO_SELECT +: 2];

   // Bit 7 of the pair register drives nothing
   genvar k;
   generate
      for (k = 0; k < cgr_pkg::PAIR_COUNT; k++) begin : g_pair
         assign channel_enable[2*k] = state.output_pair_enable[k]; // [R5]
         assign channel_enable[2*k+1] = state.output_pair_enable[k]; // [R5]
      end
   endgenerate

   assign ref_path_enable = state.global_mode_enable[cgr_pkg::POS_REF_PATH_EN +: cgr_pkg::REF_INPUTS]; // [R12]
   assign ref_input_zero_rf_sync = state.global_mode_enable[cgr_pkg::BIT_REF_ZERO_RF_SYNC]; // [R11]
   assign ref_input_one_ext_osc = state.global_mode_enable[cgr_pkg::BIT_REF_ONE_EXT_OSC]; // [R10]
   // Level, not pulse: alarms stay cleared until software writes 0 back
   assign alarm_clear = state.alarm_clear[cgr_pkg::BIT_CLEAR_ALARMS]; // [R17]

   cgr_sync_events u_events (
      .clock(clock),
      .resetn(resetn),
      .sync_pin(sync_pin),
      .general_input_pin_pulse(general_input_pin_pulse),
      .synthesis_loop_locked(synthesis_loop_locked),
      .alarm_present(alarm_present),
      .sync_mode(state.global_mode_enable[cgr_pkg::POS_SYNC_MODE +: 2]), // [R6] [R7] [R9]
      .lock_sync_disable(state.lock_sync_control[cgr_pkg::BIT_LOCK_SYNC_DISABLE]), // [R15] [R16]
      .synthesis_loop_sync(synthesis_loop_sync),
      .pulse_gen_request(pulse_gen_request),
      .feedback_divider_sync(feedback_divider_sync)
   );
endmodule : cgr_global_regs

// ### cgr_global_regs_assertions.sv
// Port-level checker for the clock global control register bank
`timescale 1ns/1ns
module cgr_global_regs_assertions (
   input wire logic clock, // System clock
   input wire logic resetn, // Asynchronous reset, active low
   input wire logic sen_n, // Serial enable, active low
   input wire logic sdio_oe, // Serial data output enable
   input wire logic sync_pin, // SYNC pin
   input wire logic general_input_pin_pulse, // General input pulse request
   input wire logic synthesis_loop_locked, // Lock status
   input wire logic [1:0] vco_select, // Oscillator selection
   input wire logic [13:0] channel_enable, // Channel enables
   input wire logic [3:0] ref_path_enable, // Reference path enables
   input wire logic alarm_clear, // Alarm clear level
   input wire logic synthesis_loop_sync, // Sync through synthesis loop
   input wire logic pulse_gen_request, // Pulse generator request
   input wire logic feedback_divider_sync // Lock sync pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [6:0] even_ch;
   logic [6:0] odd_ch;
   always_comb begin
      for (int k = 0; k < 7; k++) begin
         even_ch[k] = channel_enable[2*k];
         odd_ch[k] = channel_enable[2*k+1];
      end
   end
   a_pair_match: assert property (even_ch == odd_ch) else $error("channel pair enables differ");
   a_sync_cause: assert property (synthesis_loop_sync |-> $past(sync_pin)) else $error("sync without pin");
   a_sync_once: assert property (synthesis_loop_sync |=> !synthesis_loop_sync) else $error("sync pulse too long");
   a_pulse_cause: assert property (pulse_gen_request |-> $past(sync_pin || general_input_pin_pulse))
      else $error("pulse request without cause");
   a_gpi_pulse: assert property ($rose(general_input_pin_pulse) |=> pulse_gen_request ##1 !pulse_gen_request)
      else $error("general input did not request one pulse");
   a_pin_exclusive: assert property (synthesis_loop_sync && pulse_gen_request |-> $past(general_input_pin_pulse))
      else $error("pin caused both sync and pulse");
   // Lock sync only follows a fresh rise of the lock level
   a_lock_cause: assert property (feedback_divider_sync |-> $past(synthesis_loop_locked) && !$past(synthesis_loop_locked, 2))
      else $error("lock sync without lock");
   a_lock_once: assert property (feedback_divider_sync |=> !feedback_divider_sync [*3])
      else $error("lock sync repeated");
   a_oe_idle: assert property (sen_n |-> !sdio_oe) else $error("sdio driven outside frame");
   a_cfg_quiet: assert property (!$stable({channel_enable, ref_path_enable, vco_select, alarm_clear}) |-> !$past(sen_n))
      else $error("configuration changed outside a frame");
   c_sync: cover property (synthesis_loop_sync);
   c_pulse: cover property (pulse_gen_request);
   c_lock: cover property (feedback_divider_sync);
   c_read: cover property (sdio_oe);
endmodule : cgr_global_regs_assertions

bind cgr_global_regs cgr_global_regs_assertions cgr_global_regs_assertions_inst (.clock(clock), .resetn(resetn),
   .sen_n(sen_n), .sdio_oe(sdio_oe), .sync_pin(sync_pin), .general_input_pin_pulse(general_input_pin_pulse),
   .synthesis_loop_locked(synthesis_loop_locked), .vco_select(vco_select), .channel_enable(channel_enable),
   .ref_path_enable(ref_path_enable), .alarm_clear(alarm_clear), .synthesis_loop_sync(synthesis_loop_sync),
   .pulse_gen_request(pulse_gen_request), .feedback_divider_sync(feedback_divider_sync));

// ### cgr_host_model.sv
// Host controller model on the serial programming port
`timescale 1ns/1ns
module cgr_host_model (
   input wire logic clock, // System clock
   output logic sclk, // Serial clock to device
   output logic sen_n, // Serial enable, active low
   output logic sdio_in, // Resolved sdio wire level
   input wire logic sdio_out, // Device data bit
   input wire logic sdio_oe // Device driving sdio
);
   logic host_bit;
   assign sdio_in = sdio_oe ? sdio_out : host_bit;
   initial begin
      sclk = 1'b0;
      sen_n = 1'b1;
      host_bit = 1'b0;
   end
   // One 24-bit frame: read bit, two zero bits, 13-bit address, then one data byte
   task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd, output logic [7:0] rdv);
      logic [23:0] frame;
      frame = {rd, 2'b00, addr, wd};
      rdv = 8'h00;
      @(negedge clock);
      sen_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         // Released wire has no pull, so it toggles instead of holding a stale bit
         host_bit = (rd && i < 8) ? ~host_bit : frame[i];
         repeat (3) @(negedge clock);
         if (rd && i < 8) rdv[i] = sdio_in;
         sclk = 1'b1;
         repeat (3) @(negedge clock);
         sclk = 1'b0;
      end
      repeat (3) @(negedge clock);
      sen_n = 1'b1;
      host_bit = ~host_bit;
   endtask : xfer
endmodule : cgr_host_model

// ### clock_global_control_regs_test.sv
// Self-checking testbench for the clock global control register bank
`timescale 1ns/1ns
module clock_global_control_regs_test;
   logic clock, resetn, sclk, sen_n, sdio_in, sdio_out, sdio_oe;
   logic sync_pin, general_input_pin_pulse, synthesis_loop_locked, alarm_present;
   logic reference_loop_enable, synthesis_loop_enable, sysref_timer_enable, rf_reseed_enable;
   logic [1:0] vco_select;
   logic [13:0] channel_enable;
   logic [3:0] ref_path_enable;
   logic ref_input_zero_rf_sync, ref_input_one_ext_osc, alarm_clear;
   logic synthesis_loop_sync, pulse_gen_request, feedback_divider_sync;
   logic [7:0] shadow [3:9];
   logic [7:0] rdv;
   logic [26:0] obs;
   int error_cnt, comparisons;
   int seed_val;
   assign obs = {reference_loop_enable, synthesis_loop_enable, sysref_timer_enable, rf_reseed_enable, vco_select,
      channel_enable, ref_path_enable, ref_input_zero_rf_sync, ref_input_one_ext_osc, alarm_clear};

   cgr_global_regs cgr_global_regs_inst (.clock(clock), .resetn(resetn), .sclk(sclk), .sen_n(sen_n),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sync_pin(sync_pin),
      .general_input_pin_pulse(general_input_pin_pulse), .synthesis_loop_locked(synthesis_loop_locked),
      .alarm_present(alarm_present), .reference_loop_enable(reference_loop_enable),
      .synthesis_loop_enable(synthesis_loop_enable), .sysref_timer_enable(sysref_timer_enable),
      .rf_reseed_enable(rf_reseed_enable), .vco_select(vco_select), .channel_enable(channel_enable),
      .ref_path_enable(ref_path_enable), .ref_input_zero_rf_sync(ref_input_zero_rf_sync),
      .ref_input_one_ext_osc(ref_input_one_ext_osc), .alarm_clear(alarm_clear),
      .synthesis_loop_sync(synthesis_loop_sync), .pulse_gen_request(pulse_gen_request),
      .feedback_divider_sync(feedback_divider_sync));
   cgr_host_model cgr_host_model_inst (.clock(clock), .sclk(sclk), .sen_n(sen_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe));

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   function automatic logic [26:0] exp_out();
      logic [13:0] ch;
      for (int k = 0; k < 14; k++) ch[k] = shadow[4][k/2];
      return {shadow[3][0], shadow[3][1], shadow[3][2], shadow[3][5], shadow[3][4:3], ch, shadow[5][3:0],
         shadow[5][4], shadow[5][5], shadow[6][0]};
   endfunction : exp_out

   // Pin routing: sync, pulse, lock order in the returned bits
   function automatic logic [2:0] exp_pin(input logic [1:0] mode, input logic alarm);
      case (mode)
         2'h1: return 3'b100;
         2'h2: return 3'b010;
         2'h3: return alarm ? 3'b100 : 3'b010;
         default: return 3'b000;
      endcase
   endfunction : exp_pin

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      cgr_host_model_inst.xfer(1'b0, a, d, rdv);
      if (a >= 13'h3 && a <= 13'h9) shadow[a] = d;
   endtask : wr

   task automatic fire(input int src, input logic [2:0] exp, input string what);
      logic [2:0] seen;
      seen = 3'b000;
      @(negedge clock);
      if (src == 0) sync_pin = 1'b1;
      else if (src == 1) general_input_pin_pulse = 1'b1;
      else synthesis_loop_locked = 1'b1;
      repeat (4) begin
         @(negedge clock);
         seen = seen | {synthesis_loop_sync, pulse_gen_request, feedback_divider_sync};
      end
      {sync_pin, general_input_pin_pulse, synthesis_loop_locked} = 3'b000;
      check({29'h0, seen}, {29'h0, exp}, what);
   endtask : fire

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (100000) @(posedge clock);
      error_cnt++;
      print_verdict();
   end

   initial begin
      logic [12:0] a;
      logic [7:0] d;
      {resetn, sync_pin, general_input_pin_pulse, synthesis_loop_locked, alarm_present} = 5'b00000;
      error_cnt = 0;
      comparisons = 0;
      for (int i = 3; i <= 9; i++) shadow[i] = 8'h00;
      seed_val = $urandom(32'h7361);
      repeat (6) @(posedge clock);
      @(negedge clock) resetn = 1'b1;
      for (int i = 3; i <= 9; i++) begin
         cgr_host_model_inst.xfer(1'b1, i[12:0], 8'h00, rdv);
         check({24'h0, rdv}, 32'h0, "reset value");
      end
      check({5'h0, obs}, 32'h0, "outputs after reset");
      $display("test reset done");
      for (int n = 0; n < 24; n++) begin
         a = 13'h3 + 13'($urandom % 7);
         d = (n < 7) ? 8'hff : 8'($urandom);
         if (n >= 7 && n < 14) a = 13'(n - 4);
         if (n >= 7 && n < 14) d = 8'h00;
         wr(a, d);
         check({5'h0, obs}, {5'h0, exp_out()}, "mapped outputs");
         cgr_host_model_inst.xfer(1'b1, a, 8'h00, rdv);
         check({24'h0, rdv}, {24'h0, shadow[a]}, "read back");
      end
      $display("test readwrite done");
      wr(13'h000a, 8'h5a);
      cgr_host_model_inst.xfer(1'b1, 13'h000a, 8'h00, rdv);
      check({24'h0, rdv}, 32'h0, "unmapped read");
      check({5'h0, obs}, {5'h0, exp_out()}, "outputs after unmapped write");
      $display("test unmapped done");
      for (int m = 0; m < 8; m++) begin
         wr(13'h5, {m[1:0], 6'($urandom)});
         alarm_present = m[2];
         fire(0, exp_pin(m[1:0], m[2]), "pin event");
         fire(1, 3'b010, "general input event");
      end
      for (int s = 0; s < 2; s++) begin
         wr(13'h9, {7'($urandom), s[0]});
         fire(2, {2'b00, ~s[0]}, "lock event");
      end
      $display("test events done");
      print_verdict();
   end
endmodule : clock_global_control_regs_test
